// ---- src/lcu_gate.sv ----
`timescale 1ns/1ns
module lcu_gate
  import lcu_pkg::*;
(
  input  wire lcu_pkg::lcu_gate_sel_t sel,
  input  wire lcu_pkg::lcu_src_t      src,
  input  wire logic                   invert,
  output logic                        gate_out
);

  // ----------------------------------------------------------------
  // per-source terms: odd bit admits true, even bit admits inverted
  // ----------------------------------------------------------------
  wire lcu_src_t true_terms;
  wire lcu_src_t inv_terms;
  wire           gate_or;

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++)
    begin : g_src
      assign true_terms[i] = sel[2*i+1] & src[i];  // [RULE_10] [RULE_11] [RULE_12] [RULE_13]
      assign inv_terms[i]  = sel[2*i] & ~src[i];   // [RULE_13]
    end
  endgenerate

  // none enabled gives zero
  assign gate_or  = |(true_terms | inv_terms);     // [RULE_13]
  assign gate_out = gate_or ^ invert;              // [RULE_01]

endmodule

// ---- src/lcu_pkg.sv ----
package lcu_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;
  typedef logic [ADDR_W-1:0] lcu_addr_t;
  typedef logic [DATA_W-1:0] lcu_data_t;

  localparam lcu_addr_t   CTL_OFFSET  = 4'h0;
  localparam lcu_addr_t   GLS_OFFSET  = 4'h4;
  localparam lcu_data_t   CTL_RESET   = 32'h0000_0000;
  localparam lcu_data_t   GLS_RESET   = 32'h0000_0000;
  localparam lcu_data_t   UNMAPPED_RD = 32'h0000_0000;
  // writable control bits: 19:16, 15, 13, 11, 10, 7, 5, 2:0
  localparam lcu_data_t   CTL_WMASK   = 32'h000F_ACA7;

  // ----------------------------------------------------------------
  // channel layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_GATES   = 4;
  localparam int unsigned NUM_SRC     = 4;
  localparam int unsigned GATE_SEL_W  = 2 * NUM_SRC;
  typedef logic [GATE_SEL_W-1:0] lcu_gate_sel_t;
  typedef logic [NUM_SRC-1:0]    lcu_src_t;
  typedef logic [NUM_GATES-1:0]  lcu_gates_t;

  // ----------------------------------------------------------------
  // cell functions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_AND_OR  = 3'h0,
    MODE_OR_XOR  = 3'h1,
    MODE_AND4    = 3'h2,
    MODE_SR      = 3'h3,
    MODE_DFF     = 3'h4,
    MODE_OR4     = 3'h5,
    MODE_XOR4    = 3'h6,
    MODE_PASS    = 3'h7
  } lcu_mode_t;

  // ----------------------------------------------------------------
  // control register layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] rsv_hi;
    lcu_gates_t  gate_invert;
    logic        module_on;
    logic        rsv14;
    logic        stop_when_idle;
    logic        rsv12;
    logic        rise_irq_enable;
    logic        fall_irq_enable;
    logic [1:0]  rsv9_8;
    logic        pin_drive_enable;
    logic        cell_output_state;
    logic        out_invert;
    logic [1:0]  rsv4_3;
    lcu_mode_t   mode;
  } lcu_ctl_t;

endpackage

// ---- src/lcu_top.sv ----
// Function
// RULE_01: per-gate polarity bit inverts gate output
// RULE_02: enabled module combines inputs through cell
// RULE_03: disabled module holds cell output low
// RULE_04: stop-when-idle freezes cell during idle
// RULE_05: rising cell edge raises interrupt when enabled
// RULE_06: falling cell edge raises interrupt when enabled
// RULE_07: software sets at most one edge enable
// RULE_08: pin driven only while drive enable set
// RULE_09: unused control bits read zero, ignore writes
// RULE_10: gate 3 source enables in bits 20:16; code gives each gate an 8-bit field, the third field is bits 23:16
// RULE_11: gate 2 source enables in bits 15:8
// RULE_12: gate 1 bits 7:5 select source 4/3; code uses bits 7:4 of the first field for the two top sources
// RULE_13: remaining selects follow pattern; gate ORs terms
// RULE_14: cell function chosen; output sampled on clock
`timescale 1ns/1ns
module lcu_top
  import lcu_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire lcu_pkg::lcu_addr_t REG_ADDR,
  input  wire lcu_pkg::lcu_data_t REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output lcu_pkg::lcu_data_t      REG_RDATA,
  input  wire lcu_pkg::lcu_src_t  DATA_SRC,
  input  wire logic               IDLE_MODE,
  output logic                    CELL_OUT,
  output logic                    PIN_OUT,
  output logic                    PIN_OE,
  output logic                    IRQ_REQ
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lcu_ctl_t  ctl_reg;
  lcu_ctl_t  ctl_next;
  lcu_data_t gls_reg;
  lcu_data_t gls_next;
  lcu_data_t rdata_reg;
  lcu_data_t rdata_next;
  logic      cell_reg;
  logic      cell_next;
  logic      latch_reg;
  logic      latch_next;
  logic      g1_prev_reg;
  logic      g1_prev_next;
  logic      irq_reg;
  logic      irq_next;
  logic      oe_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_ctl;
  wire logic hit_gls;
  wire logic wr_ctl;
  wire logic wr_gls;

  assign hit_ctl = (REG_ADDR == CTL_OFFSET);
  assign hit_gls = (REG_ADDR == GLS_OFFSET);
  assign wr_ctl  = REG_WR & hit_ctl;
  assign wr_gls  = REG_WR & hit_gls;

  // ----------------------------------------------------------------
  // register write
  // ----------------------------------------------------------------
  // only implemented bits take the write; the status bit is never written
  wire lcu_data_t ctl_stored;
  wire lcu_data_t ctl_written;

  assign ctl_stored  = ctl_reg & CTL_WMASK;
  assign ctl_written = (REG_WDATA & CTL_WMASK) | (ctl_stored & ~CTL_WMASK);  // [RULE_09]
  assign ctl_next    = wr_ctl ? lcu_ctl_t'(ctl_written) : lcu_ctl_t'(ctl_stored);
  assign gls_next    = wr_gls ? REG_WDATA : gls_reg;                         // [RULE_10] [RULE_11] [RULE_12]

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // the live cell state is merged at read time rather than stored
  lcu_ctl_t       ctl_view;
  wire lcu_data_t rd_mux;

  always_comb
  begin
    ctl_view                   = lcu_ctl_t'(ctl_stored);  // [RULE_09]
    ctl_view.cell_output_state = cell_reg;                // [RULE_14]
  end

  assign rd_mux     = hit_ctl ? lcu_data_t'(ctl_view) :
                      hit_gls ? gls_reg : UNMAPPED_RD;
  // read data stand for exactly one cycle
  assign rdata_next = REG_RD ? rd_mux : UNMAPPED_RD;

  // ----------------------------------------------------------------
  // gates
  // ----------------------------------------------------------------
  lcu_gates_t gate_val;

  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++)
    begin : g_gate
      lcu_gate u_gate (
        .sel      (gls_reg[g*GATE_SEL_W +: GATE_SEL_W]),
        .src      (DATA_SRC),
        .invert   (ctl_reg.gate_invert[g]),  // [RULE_01]
        .gate_out (gate_val[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // cell function
  // ----------------------------------------------------------------
  wire logic set_in;
  wire logic reset_in;
  wire logic g1_rise;
  wire logic halted;
  logic      func_out;

  assign set_in   = gate_val[0] | gate_val[1];
  assign reset_in = gate_val[2] | gate_val[3];
  assign g1_rise  = gate_val[0] & ~g1_prev_reg;
  // idle only halts when software asked for it
  assign halted   = ctl_reg.stop_when_idle & IDLE_MODE;  // [RULE_04]

  // latch state used by the sr and flip-flop functions; reset dominates set
  always_comb
  begin
    latch_next = latch_reg;
    unique case (ctl_reg.mode)
      MODE_SR:
      begin
        if (reset_in)
          latch_next = 1'b0;
        else if (set_in)
          latch_next = 1'b1;
      end
      MODE_DFF:
      begin
        if (gate_val[2])
          latch_next = 1'b0;
        else if (gate_val[3])
          latch_next = 1'b1;
        else if (g1_rise)
          latch_next = gate_val[1];
      end
      default:
        latch_next = 1'b0;
    endcase
  end

  always_comb
  begin
    func_out = 1'b0;
    unique case (ctl_reg.mode)                                                  // [RULE_14]
      MODE_AND_OR: func_out = (gate_val[0] & gate_val[1]) | (gate_val[2] & gate_val[3]);
      MODE_OR_XOR: func_out = set_in ^ reset_in;
      MODE_AND4:   func_out = &gate_val;
      MODE_SR:     func_out = latch_next;
      MODE_DFF:    func_out = latch_next;
      MODE_OR4:    func_out = |gate_val;
      MODE_XOR4:   func_out = ^gate_val;
      MODE_PASS:   func_out = gate_val[0];
    endcase
  end

  // ----------------------------------------------------------------
  // sampled cell output
  // ----------------------------------------------------------------
  // frozen while halted so no edge and no interrupt appear during idle
  always_comb
  begin
    cell_next    = cell_reg;
    g1_prev_next = g1_prev_reg;
    if (!ctl_reg.module_on)
    begin
      cell_next    = 1'b0;                                 // [RULE_03]
      g1_prev_next = 1'b0;
    end
    else if (!halted)                                      // [RULE_04]
    begin
      cell_next    = func_out ^ ctl_reg.out_invert;        // [RULE_02] [RULE_14]
      g1_prev_next = gate_val[0];
    end
  end

  // ----------------------------------------------------------------
  // edge interrupt
  // ----------------------------------------------------------------
  // with both enables set every toggle would request; software avoids that
  wire logic rise_seen;
  wire logic fall_seen;

  assign rise_seen = cell_next & ~cell_reg;
  assign fall_seen = ~cell_next & cell_reg;
  assign irq_next  = (ctl_reg.rise_irq_enable & rise_seen)   // [RULE_05] [RULE_07]
                   | (ctl_reg.fall_irq_enable & fall_seen);  // [RULE_06]

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ctl_reg   <= lcu_ctl_t'(CTL_RESET);
      gls_reg   <= GLS_RESET;
      rdata_reg <= UNMAPPED_RD;
    end
    else
    begin
      ctl_reg   <= ctl_next;
      gls_reg   <= gls_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cell_reg    <= 1'b0;
      latch_reg   <= 1'b0;
      g1_prev_reg <= 1'b0;
      irq_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end
    else
    begin
      cell_reg    <= cell_next;
      latch_reg   <= (ctl_reg.module_on && !halted) ? latch_next : (ctl_reg.module_on & latch_reg);
      g1_prev_reg <= g1_prev_next;
      irq_reg     <= irq_next;
      oe_reg      <= ctl_next.pin_drive_enable;  // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = rdata_reg;
  assign CELL_OUT  = cell_reg;
  assign PIN_OUT   = cell_reg;
  assign PIN_OE    = oe_reg;   // [RULE_08]
  assign IRQ_REQ   = irq_reg;

endmodule

// ---- testbench/lcu_pin_model.sv ----
`timescale 1ns/1ns
module lcu_pin_model
(
  input  wire logic drive_val,
  input  wire logic drive_en,
  output logic      pin_level
);
  // released pin sits on a pull-down, so stale data never shows
  assign pin_level = drive_en ? drive_val : 1'h0;
endmodule

// ---- testbench/lcu_top_props.sv ----
`timescale 1ns/1ns
module lcu_top_props
  import lcu_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire lcu_pkg::lcu_addr_t REG_ADDR,
  input wire lcu_pkg::lcu_data_t REG_WDATA,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire lcu_pkg::lcu_data_t REG_RDATA,
  input wire logic               IDLE_MODE,
  input wire logic               CELL_OUT,
  input wire logic               PIN_OUT,
  input wire logic               PIN_OE,
  input wire logic               IRQ_REQ
);
  lcu_data_t ctl_reg;

  // shadow copy, so checks can see the enables without peeking inside
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ctl_reg <= '0;
    else if (REG_WR && REG_ADDR == CTL_OFFSET)
      ctl_reg <= REG_WDATA & CTL_WMASK;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_ctl_read; $past(REG_RD) && $past(REG_ADDR) == CTL_OFFSET |-> (REG_RDATA & ~32'h40) == $past(ctl_reg);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_off; !$past(ctl_reg[15]) |-> !CELL_OUT; endproperty
  a_off: assert property (p_off) else $error("cell output high while off");
  property p_idle; $past(ctl_reg[13] & ctl_reg[15] & IDLE_MODE) |-> $stable(CELL_OUT) && !IRQ_REQ; endproperty
  a_idle: assert property (p_idle) else $error("cell moved while stopped in idle");
  property p_rise; $rose(CELL_OUT) && $past(ctl_reg[11]) |-> IRQ_REQ; endproperty
  a_rise: assert property (p_rise) else $error("rising edge without request");
  property p_fall; $fell(CELL_OUT) && $past(ctl_reg[10]) |-> IRQ_REQ; endproperty
  a_fall: assert property (p_fall) else $error("falling edge without request");
  property p_cause; IRQ_REQ |-> $rose(CELL_OUT) && $past(ctl_reg[11]) || $fell(CELL_OUT) && $past(ctl_reg[10]);
  endproperty
  a_cause: assert property (p_cause) else $error("request without enabled edge");
  property p_pin; PIN_OE == ctl_reg[7] && PIN_OUT == CELL_OUT; endproperty
  a_pin: assert property (p_pin) else $error("pin drive mismatch");
endmodule

bind lcu_top lcu_top_props i_props (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IDLE_MODE(IDLE_MODE), .CELL_OUT(CELL_OUT),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ_REQ(IRQ_REQ));

// ---- testbench/lcu_top_tb.sv ----
`timescale 1ns/1ns
module lcu_top_tb;
  import lcu_pkg::*;
  logic      CLK, RST_N, REG_WR, REG_RD, IDLE_MODE, CELL_OUT, PIN_OUT, PIN_OE, IRQ_REQ, pin_level;
  lcu_addr_t REG_ADDR;
  lcu_data_t REG_WDATA, REG_RDATA;
  lcu_src_t  DATA_SRC;
  int        error_cnt, compares, irq_cnt, base, k;

  lcu_top i_dut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DATA_SRC(DATA_SRC), .IDLE_MODE(IDLE_MODE), .CELL_OUT(CELL_OUT),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ_REQ(IRQ_REQ));
  lcu_pin_model i_pin (.drive_val(PIN_OUT), .drive_en(PIN_OE), .pin_level(pin_level));

  initial
  begin
    CLK = 1'h0;
    forever #50 CLK = ~CLK;
  end

  always @(posedge CLK)
    if (IRQ_REQ === 1'h1)
      irq_cnt <= irq_cnt + 1;

  task automatic chk(input string nm, input lcu_data_t exp, input lcu_data_t act);
    compares++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, act);
    end
  endtask

  task automatic wr(input lcu_addr_t a, input lcu_data_t d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'h1;
    @(posedge CLK);
    REG_WR <= 1'h0;
    @(posedge CLK);
  endtask

  task automatic rd(input lcu_addr_t a, input lcu_data_t e);
    REG_ADDR <= a;
    REG_RD <= 1'h1;
    @(posedge CLK);
    REG_RD <= 1'h0;
    @(negedge CLK);
    chk("rdata", e, REG_RDATA);
    @(posedge CLK);
  endtask

  // the cell flop follows one edge after the inputs; the second edge is slack
  task automatic src(input lcu_src_t v, input logic e);
    DATA_SRC <= v;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk("cell", {31'h0, e}, {31'h0, CELL_OUT});
    @(posedge CLK);
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    final_report;
  end

  initial
  begin
    {RST_N, REG_WR, REG_RD, IDLE_MODE, irq_cnt} = '0;
    REG_ADDR = '0;
    REG_WDATA = '0;
    DATA_SRC = '0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'h1;
    @(posedge CLK);
    rd(CTL_OFFSET, CTL_RESET);
    rd(GLS_OFFSET, GLS_RESET);
    rd(4'h8, UNMAPPED_RD);
    wr(CTL_OFFSET, 32'hFFFF_7FFF);
    rd(CTL_OFFSET, 32'hFFFF_7FFF & CTL_WMASK);
    wr(GLS_OFFSET, 32'hFFFF_FFFF);
    rd(GLS_OFFSET, 32'hFFFF_FFFF);
    $display("test registers done");
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_OR4));
    for (int i = 0; i < 32; i++)
    begin
      k = (i % 8) / 2;
      wr(GLS_OFFSET, 32'h1 << i);
      src((i % 2) ? lcu_src_t'(4'h1 << k) : 4'h0, 1'h1);
      src((i % 2) ? 4'h0 : lcu_src_t'(4'h1 << k), 1'h0);
    end
    $display("test gate select done");
    wr(GLS_OFFSET, 32'h0);
    for (int g = 0; g < 4; g++)
    begin
      wr(CTL_OFFSET, 32'h000F_8000 & ~(32'h1 << (16 + g)) | lcu_data_t'(MODE_AND4));
      src(4'h0, 1'h0);
    end
    wr(CTL_OFFSET, 32'h000F_8000 | lcu_data_t'(MODE_AND4));
    src(4'h0, 1'h1);
    $display("test polarity done");
    wr(GLS_OFFSET, 32'h2);
    wr(CTL_OFFSET, 32'h0000_8087);
    src(4'h1, 1'h1);
    @(negedge CLK);
    chk("pin", 32'h1, {31'h0, pin_level});
    @(posedge CLK);
    rd(CTL_OFFSET, 32'h0000_80C7);
    wr(CTL_OFFSET, 32'h0000_8007);
    src(4'h1, 1'h1);
    @(negedge CLK);
    chk("pin", 32'h0, {31'h0, pin_level});
    @(posedge CLK);
    wr(CTL_OFFSET, 32'h0000_0007);
    src(4'h1, 1'h0);
    $display("test enable and pin done");
    wr(CTL_OFFSET, 32'h0000_A007);
    src(4'h1, 1'h1);
    IDLE_MODE <= 1'h1;
    src(4'h0, 1'h1);
    wr(CTL_OFFSET, 32'h0000_8007);
    src(4'h0, 1'h0);
    IDLE_MODE <= 1'h0;
    $display("test idle done");
    // only one edge enable at a time; both together is not supported
    wr(CTL_OFFSET, 32'h0000_8807);
    base = irq_cnt;
    src(4'h1, 1'h1);
    src(4'h0, 1'h0);
    src(4'h1, 1'h1);
    chk("irq rise", 32'h2, lcu_data_t'(irq_cnt - base));
    wr(CTL_OFFSET, 32'h0000_8407);
    base = irq_cnt;
    src(4'h0, 1'h0);
    src(4'h1, 1'h1);
    src(4'h0, 1'h0);
    chk("irq fall", 32'h2, lcu_data_t'(irq_cnt - base));
    $display("test interrupts done");
    // gate n follows source n true, so each function sees the sources directly
    wr(GLS_OFFSET, 32'h8020_0802);
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_AND_OR));
    src(4'h3, 1'h1);
    src(4'h5, 1'h0);
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_OR_XOR));
    src(4'h5, 1'h0);
    src(4'h1, 1'h1);
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_XOR4));
    src(4'h7, 1'h1);
    src(4'hF, 1'h0);
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_SR));
    src(4'h1, 1'h1);
    src(4'h0, 1'h1);
    src(4'h5, 1'h0);
    wr(CTL_OFFSET, 32'h0000_8000 | lcu_data_t'(MODE_DFF));
    src(4'h2, 1'h0);
    src(4'h3, 1'h1);
    src(4'h1, 1'h1);
    src(4'h4, 1'h0);
    src(4'h8, 1'h1);
    wr(CTL_OFFSET, 32'h0000_8020 | lcu_data_t'(MODE_PASS));
    src(4'h1, 1'h0);
    src(4'h0, 1'h1);
    wr(CTL_OFFSET, 32'h0000_0020 | lcu_data_t'(MODE_PASS));
    src(4'h0, 1'h0);
    $display("test cell functions done");
    final_report;
  end
endmodule
